/* logic/kbl_defines.svh */
// keypad interrupt latch: offsets, field positions, reset values, fixed addresses
// assumes inclusion by bare name from any design file
`ifndef KBL_DEFINES_SVH
`define KBL_DEFINES_SVH

// ****************************************
// register byte offsets on the apb
// ****************************************
`define KBL_OFS_SCR 8'h00
`define KBL_OFS_EN 8'h04
`define KBL_OFS_PA_DAT 8'h08
`define KBL_OFS_PA_DIR 8'h0C
`define KBL_OFS_PD_DAT 8'h10
`define KBL_OFS_PD_DIR 8'h14

// ****************************************
// status/control field positions
// ****************************************
`define KBL_SCR_FLAG 3
`define KBL_SCR_ACK 2
`define KBL_SCR_MASK 1
`define KBL_SCR_MODE 0

// ****************************************
// reset values and constants
// ****************************************
`define KBL_RST_BYTE 8'h00
`define KBL_RST_WORD 32'h0000_0000
`define KBL_PIN_IDLE 8'hFF
`define KBL_VEC_HI_ADDR 16'hFFDE
`define KBL_VEC_LO_ADDR 16'hFFDF

`endif

/* logic/kbl_pkg.sv */
// keypad interrupt latch: shared types and pin-map functions
// assumes kbl_defines.svh is on the include path
package kbl_pkg;
    typedef logic [7:0] kbl_byte_t;
    typedef enum logic {KBL_EDGE_ONLY, KBL_EDGE_LEVEL} kbl_trig_e;

    // keypad inputs 0..3 sit on port a bits 0..3
    function automatic kbl_byte_t kbl_a_mask(input kbl_byte_t en);
        kbl_a_mask = {4'h0, en[3:0]};
    endfunction

    // keypad inputs 4..7 sit on port d bits 4..7
    function automatic kbl_byte_t kbl_d_mask(input kbl_byte_t en);
        kbl_d_mask = {en[7:4], 4'h0};
    endfunction
endpackage

/* logic/kbl_port.sv */
// keypad interrupt latch: port a/d pad control, pull-ups and direction override
// assumes the pad wires out/oe themselves; pull-up resistors sit in the pad
`timescale 1ns/1ns
`include "kbl_defines.svh"
module kbl_port import kbl_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    kbl_port_if.pad port
);
    kbl_byte_t a_key;
    kbl_byte_t d_key;

    assign a_key = kbl_a_mask(port.enable);
    assign d_key = kbl_d_mask(port.enable);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port.a_out <= `KBL_RST_BYTE;
            port.d_out <= `KBL_RST_BYTE;
        end else begin
            port.a_out <= port.dat_a;
            port.d_out <= port.dat_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port.a_oe <= `KBL_RST_BYTE;
            port.d_oe <= `KBL_RST_BYTE;
        end else begin
            port.a_oe <= port.dir_a & ~a_key;
            port.d_oe <= port.dir_d & ~d_key;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port.a_pullup <= `KBL_RST_BYTE;
            port.d_pullup <= `KBL_RST_BYTE;
        end else begin
            port.a_pullup <= a_key;
            port.d_pullup <= d_key;
        end
    end
endmodule

/* logic/kbl_port_if.sv */
// keypad interrupt latch: carrier between control core and pad logic
// assumes one clock domain; the pad side owns the pin flops
`timescale 1ns/1ns
interface kbl_port_if;
    import kbl_pkg::*;
    kbl_byte_t enable;
    kbl_byte_t dat_a;
    kbl_byte_t dir_a;
    kbl_byte_t dat_d;
    kbl_byte_t dir_d;
    kbl_byte_t a_out;
    kbl_byte_t a_oe;
    kbl_byte_t a_pullup;
    kbl_byte_t d_out;
    kbl_byte_t d_oe;
    kbl_byte_t d_pullup;
    modport ctl(output enable, dat_a, dir_a, dat_d, dir_d,
                input a_out, a_oe, a_pullup, d_out, d_oe, d_pullup);
    modport pad(input enable, dat_a, dir_a, dat_d, dir_d,
                output a_out, a_oe, a_pullup, d_out, d_oe, d_pullup);
endinterface

/* logic/kbl_sync.sv */
// keypad interrupt latch: two-flop synchroniser for the pin levels
// assumes pins idle high, so flops reset to ones
`timescale 1ns/1ns
`include "kbl_defines.svh"
module kbl_sync import kbl_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire kbl_byte_t i_d,
    output kbl_byte_t o_q
);
    kbl_byte_t meta;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= `KBL_PIN_IDLE;
            o_q <= `KBL_PIN_IDLE;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule

/* logic/kbl_top.sv */
// keypad interrupt latch: apb registers, request latch, mask and pin control
// assumes an apb master on i_clk and a cpu that pulses i_vector_fetch
`timescale 1ns/1ns
`include "kbl_defines.svh"
module kbl_top import kbl_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire kbl_byte_t i_port_a_pins,
    output kbl_byte_t o_port_a_pins,
    output kbl_byte_t o_port_a_oe,
    output kbl_byte_t o_port_a_pullup,
    input wire kbl_byte_t i_port_d_pins,
    output kbl_byte_t o_port_d_pins,
    output kbl_byte_t o_port_d_oe,
    output kbl_byte_t o_port_d_pullup,
    input wire logic i_vector_fetch,
    input wire logic i_break_state,
    input wire logic i_break_clear_enable,
    output logic o_irq_req,
    output logic o_wake_req,
    output logic [15:0] o_vector_addr
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ****************************************
    // pins and pad logic
    // ****************************************
    kbl_port_if port ();
    kbl_byte_t pa_sync;
    kbl_byte_t pd_sync;
    kbl_byte_t keypad_input_enable;
    kbl_byte_t dat_a;
    kbl_byte_t dir_a;
    kbl_byte_t dat_d;
    kbl_byte_t dir_d;

    kbl_sync u_sync_a (.i_clk(i_clk), .i_rst_n(rst_n), .i_d(i_port_a_pins), .o_q(pa_sync));
    kbl_sync u_sync_d (.i_clk(i_clk), .i_rst_n(rst_n), .i_d(i_port_d_pins), .o_q(pd_sync));
    kbl_port u_port (.i_clk(i_clk), .i_rst_n(rst_n), .port(port.pad));

    assign port.enable = keypad_input_enable;
    assign port.dat_a = dat_a;
    assign port.dir_a = dir_a;
    assign port.dat_d = dat_d;
    assign port.dir_d = dir_d;
    assign o_port_a_pins = port.a_out;
    assign o_port_a_oe = port.a_oe;
    assign o_port_a_pullup = port.a_pullup;
    assign o_port_d_pins = port.d_out;
    assign o_port_d_oe = port.d_oe;
    assign o_port_d_pullup = port.d_pullup;

    // ****************************************
    // apb slave
    // ****************************************
    logic apb_take;
    logic wr_en;
    logic mapped;
    logic [31:0] rd_word;
    logic keypad_mask_bit;
    kbl_trig_e keypad_sensitivity_bit;
    logic keypad_pending_flag;

    assign apb_take = i_psel & i_penable & ~o_pready;
    assign wr_en = i_psel & i_penable & o_pready & i_pwrite;

    always_comb begin
        rd_word = `KBL_RST_WORD;
        mapped = 1'b1;
        unique case (i_paddr)
            // flag ignores mask; ack reads zero
            `KBL_OFS_SCR: begin
                rd_word[`KBL_SCR_FLAG] = keypad_pending_flag;
                rd_word[`KBL_SCR_MASK] = keypad_mask_bit;
                rd_word[`KBL_SCR_MODE] = (keypad_sensitivity_bit == KBL_EDGE_LEVEL);
            end
            `KBL_OFS_EN: rd_word[7:0] = keypad_input_enable;
            // pin level only with direction zero
            `KBL_OFS_PA_DAT: rd_word[7:0] = (dir_a & dat_a) | (~dir_a & pa_sync);
            `KBL_OFS_PA_DIR: rd_word[7:0] = dir_a;
            `KBL_OFS_PD_DAT: rd_word[7:0] = (dir_d & dat_d) | (~dir_d & pd_sync);
            `KBL_OFS_PD_DIR: rd_word[7:0] = dir_d;
            default: mapped = 1'b0;
        endcase
    end

    // answer one cycle into the access phase, so every transfer takes three cycles
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= `KBL_RST_WORD;
        end else begin
            o_pready <= apb_take;
            o_pslverr <= apb_take & ~mapped;
            if (apb_take && !i_pwrite) begin
                o_prdata <= rd_word;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            keypad_input_enable <= `KBL_RST_BYTE;
        end else if (wr_en && i_paddr == `KBL_OFS_EN) begin
            keypad_input_enable <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_a <= `KBL_RST_BYTE;
            dir_a <= `KBL_RST_BYTE;
            dat_d <= `KBL_RST_BYTE;
            dir_d <= `KBL_RST_BYTE;
        end else if (wr_en) begin
            if (i_paddr == `KBL_OFS_PA_DAT) dat_a <= i_pwdata[7:0];
            if (i_paddr == `KBL_OFS_PA_DIR) dir_a <= i_pwdata[7:0];
            if (i_paddr == `KBL_OFS_PD_DAT) dat_d <= i_pwdata[7:0];
            if (i_paddr == `KBL_OFS_PD_DIR) dir_d <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            keypad_mask_bit <= 1'b0;
            keypad_sensitivity_bit <= KBL_EDGE_ONLY;
        end else if (wr_en && i_paddr == `KBL_OFS_SCR) begin
            keypad_mask_bit <= i_pwdata[`KBL_SCR_MASK];
            keypad_sensitivity_bit <= i_pwdata[`KBL_SCR_MODE] ? KBL_EDGE_LEVEL : KBL_EDGE_ONLY;
        end
    end

    // ****************************************
    // request latch
    // ****************************************
    kbl_byte_t keypad_input;
    logic all_high;
    logic prev_all_high;
    logic fall;
    logic sw_ack;
    logic ack;
    logic ack_seen;
    logic clear;

    assign keypad_input = kbl_a_mask(pa_sync) | kbl_d_mask(pd_sync);
    assign all_high = &(keypad_input | ~keypad_input_enable);
    // first fall after all high; none while one is low
    assign fall = prev_all_high & ~all_high;
    // write-one ack; blocked in break without clear enable
    assign sw_ack = wr_en && i_paddr == `KBL_OFS_SCR && i_pwdata[`KBL_SCR_ACK]
                    && (!i_break_state || i_break_clear_enable);
    assign ack = i_vector_fetch | sw_ack;
    // ack and all-high in any order; edge mode clears at once
    assign clear = (keypad_sensitivity_bit == KBL_EDGE_LEVEL) ? ((ack | ack_seen) & all_high) : ack;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_all_high <= 1'b1;
        end else begin
            prev_all_high <= all_high;
        end
    end

    // new fall wins over ack; level mode holds while low
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            keypad_pending_flag <= 1'b0;
        end else begin
            keypad_pending_flag <= fall | (keypad_pending_flag & ~clear);
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_seen <= 1'b0;
        end else if (fall || clear) begin
            ack_seen <= 1'b0;
        end else if (ack && keypad_pending_flag) begin
            ack_seen <= 1'b1;
        end
    end

    // mask gate; wake from wait or stop; vector
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_irq_req <= 1'b0;
            o_wake_req <= 1'b0;
            o_vector_addr <= `KBL_VEC_HI_ADDR;
        end else begin
            o_irq_req <= keypad_pending_flag & ~keypad_mask_bit;
            o_wake_req <= keypad_pending_flag & ~keypad_mask_bit;
            o_vector_addr <= `KBL_VEC_HI_ADDR;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    sequence seq_scr_read;
        apb_take && !i_pwrite && i_paddr == `KBL_OFS_SCR;
    endsequence

    sequence seq_pending_no_edge;
        keypad_pending_flag && !fall;
    endsequence

    AST_FALL_LATCHES: assert property (fall |=> keypad_pending_flag)
        else $error("fall did not latch request");
    AST_NO_FALL_WHILE_LOW: assert property (
        (!prev_all_high && !keypad_pending_flag) |=> !keypad_pending_flag)
        else $error("request latched while an input was low");
    AST_LEVEL_HOLDS: assert property (
        (keypad_sensitivity_bit == KBL_EDGE_LEVEL && keypad_pending_flag && !all_high)
        |=> keypad_pending_flag)
        else $error("level request dropped while input low");
    AST_LEVEL_CLEARS: assert property (
        (seq_pending_no_edge and (keypad_sensitivity_bit == KBL_EDGE_LEVEL && ack_seen
        && all_high)) |=> !keypad_pending_flag)
        else $error("level request not cleared after ack and release");
    AST_EDGE_ACK_CLEARS: assert property (
        (seq_pending_no_edge and (keypad_sensitivity_bit == KBL_EDGE_ONLY && sw_ack))
        |=> !keypad_pending_flag ##1 !o_irq_req)
        else $error("edge request not cleared by ack");
    AST_BREAK_PROTECT: assert property (
        (keypad_pending_flag && i_break_state && !i_break_clear_enable && !i_vector_fetch
        && !ack_seen)
        |=> keypad_pending_flag)
        else $error("ack changed latch during break");
    AST_MASK_GATES: assert property (
        keypad_mask_bit |=> !o_irq_req && !o_wake_req)
        else $error("masked request reached cpu");
    AST_FLAG_READ: assert property (
        seq_scr_read ##1 o_pready |-> o_prdata[`KBL_SCR_FLAG] == $past(keypad_pending_flag)
        && !o_prdata[`KBL_SCR_ACK])
        else $error("flag readback wrong or ack not zero");
    AST_PULLUP: assert property (
        ##1 o_port_a_pullup == kbl_a_mask($past(keypad_input_enable))
        && o_port_d_pullup == kbl_d_mask($past(keypad_input_enable)))
        else $error("pull-up does not follow enable");
    AST_FORCE_INPUT: assert property (
        ##1 ((o_port_a_oe & kbl_a_mask($past(keypad_input_enable)))
        | (o_port_d_oe & kbl_d_mask($past(keypad_input_enable)))) == 8'h00)
        else $error("enabled keypad pin driven");
endmodule

/* sim/kbl_keypad_model.sv */
// keypad partner: switches to ground on the shared port a/d pins
// assumes pull-ups and output drive come from the block under test
`timescale 1ns/1ns
module kbl_keypad_model import kbl_pkg::*; (
    input wire logic i_clk,
    input wire kbl_byte_t i_keys,
    input wire kbl_byte_t i_a_out,
    input wire kbl_byte_t i_a_oe,
    input wire kbl_byte_t i_a_pu,
    input wire kbl_byte_t i_d_out,
    input wire kbl_byte_t i_d_oe,
    input wire kbl_byte_t i_d_pu,
    output kbl_byte_t o_pin_a,
    output kbl_byte_t o_pin_d
);
    // undriven pin without pull-up wanders, never a settled level
    kbl_byte_t wander = 8'h55;
    kbl_byte_t press_a;
    kbl_byte_t press_d;

    always @(posedge i_clk) begin
        wander <= ~wander;
    end

    assign press_a = {4'h0, i_keys[3:0]};
    assign press_d = {i_keys[7:4], 4'h0};
    assign o_pin_a = (i_a_oe & i_a_out) | (~i_a_oe & ~press_a & (i_a_pu | wander));
    assign o_pin_d = (i_d_oe & i_d_out) | (~i_d_oe & ~press_d & (i_d_pu | wander));
endmodule

/* sim/test_keypad_interrupt_latch.sv */
// bench for the keypad interrupt latch: apb master, keypad model, scenarios
// assumes one 100 MHz clock and the one-wait-state apb slave of the top
`timescale 1ns/1ns
`include "kbl_defines.svh"
module test_keypad_interrupt_latch import kbl_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic vf = 1'b0;
    logic brk = 1'b0;
    logic bce = 1'b0;
    logic irq;
    logic wake;
    logic [15:0] vec;
    kbl_byte_t keys = 8'h00;
    kbl_byte_t pin_a, pin_d, a_out, a_oe, a_pu, d_out, d_oe, d_pu;
    int miscompares = 0;
    int check_count = 0;

    always #5 clk = ~clk;

    kbl_top i_kbl_top (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_port_a_pins(pin_a),
        .o_port_a_pins(a_out), .o_port_a_oe(a_oe), .o_port_a_pullup(a_pu),
        .i_port_d_pins(pin_d), .o_port_d_pins(d_out), .o_port_d_oe(d_oe),
        .o_port_d_pullup(d_pu), .i_vector_fetch(vf), .i_break_state(brk),
        .i_break_clear_enable(bce), .o_irq_req(irq), .o_wake_req(wake),
        .o_vector_addr(vec));

    kbl_keypad_model i_kbl_keypad_model (.i_clk(clk), .i_keys(keys), .i_a_out(a_out),
        .i_a_oe(a_oe), .i_a_pu(a_pu), .i_d_out(d_out), .i_d_oe(d_oe), .i_d_pu(d_pu),
        .o_pin_a(pin_a), .o_pin_d(pin_d));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        check(d, exp);
    endtask

    // keys change after an edge; a fall needs 3 edges to latch
    task automatic key(input kbl_byte_t v, input int settle);
        @(posedge clk);
        keys <= v;
        tick(settle);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rdchk(`KBL_OFS_SCR, 32'h0);
        rdchk(`KBL_OFS_EN, 32'h0);
        check(irq, 1'b0);
        check(vec, 16'hFFDE);
        check({a_pu, d_pu}, 16'h0000);
    endtask

    task automatic t_unmapped;
        logic [31:0] d;
        logic e;
        apb(1'b1, 8'h40, 32'hFF, d, e);
        check(e, 1'b1);
        apb(1'b0, 8'h40, 32'h0, d, e);
        check(e, 1'b1);
        check(d, 32'h0);
    endtask

    task automatic t_init;
        logic [31:0] d;
        logic e;
        wr(`KBL_OFS_PA_DAT, 32'h01);
        wr(`KBL_OFS_PA_DIR, 32'h01);
        wr(`KBL_OFS_PD_DAT, 32'h10);
        wr(`KBL_OFS_PD_DIR, 32'h10);
        tick(2);
        check({a_oe[0], d_oe[4], a_out[0], d_out[4]}, 4'hF);
        wr(`KBL_OFS_SCR, 32'h02);
        wr(`KBL_OFS_EN, 32'h11);
        wr(`KBL_OFS_SCR, 32'h06);
        wr(`KBL_OFS_SCR, 32'h00);
        check(a_pu, 8'h01);
        check(d_pu, 8'h10);
        check(a_oe[0], 1'b0);
        check(d_oe, 8'h00);
        rdchk(`KBL_OFS_PD_DIR, 32'h10);
        key(8'h02, 4);
        apb(1'b0, `KBL_OFS_PA_DAT, 32'h0, d, e);
        check(d[1:0], 2'b01);
        rdchk(`KBL_OFS_SCR, 32'h0);
        key(8'h00, 2);
    endtask

    task automatic t_edge;
        key(8'h01, 6);
        rdchk(`KBL_OFS_SCR, 32'h8);
        check({irq, wake}, 2'b11);
        wr(`KBL_OFS_SCR, 32'h04);
        tick(2);
        check(irq, 1'b0);
        rdchk(`KBL_OFS_SCR, 32'h0);
        key(8'h11, 6);
        rdchk(`KBL_OFS_SCR, 32'h0);
        key(8'h00, 4);
        key(8'h10, 6);
        rdchk(`KBL_OFS_SCR, 32'h8);
        wr(`KBL_OFS_SCR, 32'h02);
        tick(2);
        check({irq, wake}, 2'b00);
        rdchk(`KBL_OFS_SCR, 32'hA);
        wr(`KBL_OFS_SCR, 32'h06);
        rdchk(`KBL_OFS_SCR, 32'h2);
        key(8'h00, 4);
        wr(`KBL_OFS_SCR, 32'h00);
    endtask

    task automatic t_level;
        wr(`KBL_OFS_SCR, 32'h01);
        key(8'h01, 6);
        wr(`KBL_OFS_SCR, 32'h05);
        tick(3);
        rdchk(`KBL_OFS_SCR, 32'h9);
        key(8'h00, 6);
        rdchk(`KBL_OFS_SCR, 32'h1);
        key(8'h10, 6);
        key(8'h00, 6);
        rdchk(`KBL_OFS_SCR, 32'h9);
        @(posedge clk);
        vf <= 1'b1;
        @(posedge clk);
        vf <= 1'b0;
        tick(2);
        rdchk(`KBL_OFS_SCR, 32'h1);
        wr(`KBL_OFS_SCR, 32'h00);
    endtask

    task automatic t_break;
        brk <= 1'b1;
        key(8'h01, 6);
        wr(`KBL_OFS_SCR, 32'h04);
        rdchk(`KBL_OFS_SCR, 32'h8);
        bce <= 1'b1;
        wr(`KBL_OFS_SCR, 32'h04);
        tick(1);
        brk <= 1'b0;
        bce <= 1'b0;
        tick(2);
        rdchk(`KBL_OFS_SCR, 32'h0);
        key(8'h00, 4);
    endtask

    task automatic t_reset_mid;
        wr(`KBL_OFS_SCR, 32'h01);
        key(8'h01, 6);
        check(irq, 1'b1);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(4);
        check(irq, 1'b0);
        rdchk(`KBL_OFS_SCR, 32'h0);
        key(8'h00, 2);
    endtask

    initial begin
        tick(6);
        rst_n <= 1'b1;
        tick(4);
        t_reset();
        t_unmapped();
        t_init();
        t_edge();
        t_level();
        t_break();
        t_reset_mid();
        tally_and_finish();
    end
endmodule
